//--- hw/vsc_pkg.sv
// vsc_pkg: constants, register map and types of the valley skip / soft-start control.
// assumes a 125 MHz mclk; every time below is turned into cycles of that clock.
package vsc_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int UPDATE_PERIOD_MS = 48;
	localparam int UPDATE_CYC = UPDATE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SS_TIME_MS = 12;
	localparam int SS_STEPS = 4;
	localparam int SS_STEP_CYC = SS_TIME_MS * 1000000 / (CLK_PERIOD_NS * SS_STEPS);
	localparam int RS_TIME_NS = 2000;
	localparam int RS_CYC = (RS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_MAX_US = 50;
	localparam int OFF_MAX_CYC = OFF_MAX_US * 1000 / CLK_PERIOD_NS;

	// counter widths
	localparam int UPD_W = 23;
	localparam int SS_W = 19;
	localparam int OFF_W = 13;

	// skip, zero-crossing and soft-start step counters
	localparam logic [2:0] SKIP_MIN = 3'h1;
	localparam logic [2:0] SKIP_MAX = 3'h7;
	localparam logic [2:0] SKIP_RST = 3'h1;
	localparam logic [2:0] XING_MAX = 3'h7;
	localparam logic [1:0] SS_LAST_IDX = 2'h3;

	// current-sense limit in millivolts
	localparam int LIM_W = 10;
	localparam logic [9:0] SS_START_MV = 10'h140;
	localparam logic [9:0] SS_FINAL_MV = 10'h3e8;
	localparam logic [9:0] SS_STEP_MV = 10'h0aa;

	// register byte offsets
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ZONE = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_LIMIT = 4'hc;

	// field positions and reset values
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int ZONE_W = 16;
	localparam int ZL_LOWLINE_LSB = 0;
	localparam int ZH_LOWLINE_LSB = 4;
	localparam int ZL_HIGHLINE_LSB = 8;
	localparam int ZH_HIGHLINE_LSB = 12;
	localparam logic [15:0] ZONE_RST = 16'h7846;
	localparam int ST_SKIP_LSB = 0;
	localparam int ST_XING_LSB = 4;
	localparam int ST_GATE_BIT = 8;
	localparam int ST_STATE_LSB = 12;
	localparam int ST_LINE_BIT = 16;
	localparam int ST_STARTOFF_BIT = 17;
	localparam int LIM_IDX_LSB = 16;

	// comparator flags coming from the analog front end
	typedef struct packed {
		logic line_high;
		logic cs_trip;
		logic xing_above;
		logic supply_on;
		logic fdbk_over_reset;
		logic fdbk_over_high;
		logic fdbk_over_low;
	} vsc_cmp_t;

	localparam int CMP_W = 7;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SOFT = 3'b010,
		ST_RUN = 3'b100
	} vsc_state_t;

endpackage : vsc_pkg

//--- hw/vsc_sync.sv
// vsc_sync: two flip-flop synchroniser for a group of level inputs.
// assumes each bit is a slow level; the first stage is read only by the second.
`timescale 1ns/1ns
`default_nettype none
module vsc_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// two stages, cleared to zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule : vsc_sync
`default_nettype wire

//--- hw/vsc_ctrl.sv
// vsc_ctrl: valley skip counter, zero-crossing count, switch-on gate and soft-start.
// assumes comparator flags arrive asynchronously and software uses Avalon-MM.
//
// Function
// - evaluate feedback once per 48 ms period
// - always below low zone: count up to 7
// - above low, never above high: hold
// - above high, not reset level: down to 1
// - above reset threshold: force counter to 1
// - skip counter always stays within 1 to 7
// - skip counter starts at 1 after start-up
// - skip value is valleys counted before switch-on
// - 12 ms soft-start, four steps 0.32 V to 1 V
// - supply on: stop startup source, begin soft-start
// - zone thresholds chosen by detected line level
// - zero-crossing count 0-7, cleared while gate high
// - after ringing time, switch on when count >= skip
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module vsc_ctrl
	import vsc_pkg::*;
#(
	parameter int UPDATE_CYCLES = UPDATE_CYC,
	parameter int SS_STEP_CYCLES = SS_STEP_CYC,
	parameter int OFF_MAX_CYCLES = OFF_MAX_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire vsc_cmp_t cmp_in,
	output logic gate_drive,
	output logic startup_off,
	output logic [2:0] skip_count,
	output logic [LIM_W-1:0] cs_limit_mv,
	output logic [3:0] low_zone_threshold,
	output logic [3:0] high_zone_threshold
);

	localparam logic [UPD_W-1:0] UPD_LAST = UPD_W'(UPDATE_CYCLES - 1);
	localparam logic [SS_W-1:0] SS_LAST = SS_W'(SS_STEP_CYCLES - 1);
	localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(OFF_MAX_CYCLES);
	localparam logic [OFF_W-1:0] RS_DONE = OFF_W'(RS_CYC);

	vsc_cmp_t cmp_s;
	vsc_state_t state_q, state_d;
	logic [UPD_W-1:0] upd_cnt_q;
	logic [SS_W-1:0] ss_cnt_q;
	logic [1:0] ss_idx_q;
	logic [OFF_W-1:0] off_cnt_q;
	logic [2:0] skip_q, skip_d;
	logic [2:0] xing_q, xing_d;
	logic seen_low_q, seen_high_q, seen_reset_q;
	logic xing_prev_q;
	wire gate_on_go;
	logic gate_q, startup_off_q;
	logic [LIM_W-1:0] limit_q;
	logic [3:0] low_thr_q, high_thr_q;
	logic ctrl_en_q;
	logic [ZONE_W-1:0] zone_q;
	logic [31:0] rdata_q;
	logic wait_q;

	// comparator flags pass two flops before any logic
	vsc_sync #(
		.W(CMP_W)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(cmp_in),
		.q(cmp_s)
	);

	// update period and feedback observations
	wire period_end = (upd_cnt_q == UPD_LAST);
	wire low_now = seen_low_q | cmp_s.fdbk_over_low;
	wire high_now = seen_high_q | cmp_s.fdbk_over_high;
	wire reset_now = seen_reset_q | cmp_s.fdbk_over_reset;
	wire skip_at_max = (skip_q == SKIP_MAX);
	wire skip_at_min = (skip_q == SKIP_MIN);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			upd_cnt_q <= '0;
		end else begin
			upd_cnt_q <= period_end ? '0 : upd_cnt_q + 1'b1;
		end
	end

	// sticky feedback flags, restarted with each period
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			seen_low_q <= 1'b0;
			seen_high_q <= 1'b0;
			seen_reset_q <= 1'b0;
		end else begin
			seen_low_q <= low_now & ~period_end;
			seen_high_q <= high_now & ~period_end;
			seen_reset_q <= reset_now & ~period_end;
		end
	end

	// skip counter decision, only at period end
	always_comb begin
		skip_d = skip_q;
		if (period_end) begin
			if (reset_now) begin
				skip_d = SKIP_MIN;
			end else if (high_now) begin
				if (!skip_at_min) begin
					skip_d = skip_q - 3'h1;
				end
			end else if (!low_now) begin
				if (!skip_at_max) begin
					skip_d = skip_q + 3'h1;
				end
			end
			// low seen, high not seen: hold
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skip_q <= SKIP_RST;
		end else begin
			skip_q <= skip_d;
		end
	end

	// zero-crossing counter, cleared on the switch-on edge so gate high never shows a count
	wire xing_fall = xing_prev_q & ~cmp_s.xing_above;

	always_comb begin
		xing_d = xing_q;
		if (gate_q || gate_on_go) begin
			xing_d = 3'h0;
		end else if (xing_fall && xing_q != XING_MAX) begin
			xing_d = xing_q + 3'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			xing_prev_q <= 1'b0;
			xing_q <= 3'h0;
		end else begin
			xing_prev_q <= cmp_s.xing_above;
			xing_q <= xing_d;
		end
	end

	// off-time counter: ringing suppression and maximum off time
	wire rs_done = (off_cnt_q >= RS_DONE);
	wire off_max = (off_cnt_q == OFF_LAST);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			off_cnt_q <= '0;
		end else if (gate_q) begin
			off_cnt_q <= '0;
		end else if (!off_max) begin
			off_cnt_q <= off_cnt_q + 1'b1;
		end
	end

	// switch-on and switch-off decisions
	wire sw_ok = (state_q != ST_IDLE) & ctrl_en_q;
	wire valley_ok = rs_done & (xing_q >= skip_q);
	assign gate_on_go = sw_ok & ~gate_q & (valley_ok | off_max);
	wire gate_off_go = gate_q & (cmp_s.cs_trip | ~sw_ok);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gate_q <= 1'b0;
		end else if (gate_on_go) begin
			gate_q <= 1'b1;
		end else if (gate_off_go) begin
			gate_q <= 1'b0;
		end
	end

	// start-up and soft-start sequence
	wire step_end = (state_q == ST_SOFT) & (ss_cnt_q == SS_LAST);
	wire ss_final = step_end & (ss_idx_q == SS_LAST_IDX);

	always_comb begin
		case (state_q)
			ST_IDLE: state_d = cmp_s.supply_on ? ST_SOFT : ST_IDLE;
			ST_SOFT: state_d = ss_final ? ST_RUN : ST_SOFT;
			ST_RUN: state_d = ST_RUN;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			startup_off_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == ST_IDLE && cmp_s.supply_on) begin
				startup_off_q <= 1'b1;
			end
		end
	end

	// step timer and limit level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ss_cnt_q <= '0;
			ss_idx_q <= 2'h0;
			limit_q <= SS_START_MV;
		end else if (state_q != ST_SOFT) begin
			ss_cnt_q <= '0;
			ss_idx_q <= 2'h0;
			limit_q <= (state_q == ST_RUN) ? SS_FINAL_MV : SS_START_MV;
		end else if (step_end) begin
			ss_cnt_q <= '0;
			ss_idx_q <= ss_idx_q + 2'h1;
			limit_q <= ss_final ? SS_FINAL_MV : limit_q + SS_STEP_MV;
		end else begin
			ss_cnt_q <= ss_cnt_q + 1'b1;
		end
	end

	// zone thresholds follow the line level
	wire [3:0] low_thr_d = cmp_s.line_high ? zone_q[ZL_HIGHLINE_LSB +: 4] :
		zone_q[ZL_LOWLINE_LSB +: 4];
	wire [3:0] high_thr_d = cmp_s.line_high ? zone_q[ZH_HIGHLINE_LSB +: 4] :
		zone_q[ZH_LOWLINE_LSB +: 4];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_thr_q <= ZONE_RST[ZL_LOWLINE_LSB +: 4];
			high_thr_q <= ZONE_RST[ZH_LOWLINE_LSB +: 4];
		end else begin
			low_thr_q <= low_thr_d;
			high_thr_q <= high_thr_d;
		end
	end

	// bus decode: one wait cycle, then the answer
	wire req = avs_read | avs_write;
	wire wr_fire = avs_write & ~wait_q;
	wire hit_ctrl = (avs_address == REG_CTRL);
	wire hit_zone = (avs_address == REG_ZONE);
	wire hit_status = (avs_address == REG_STATUS);
	wire hit_limit = (avs_address == REG_LIMIT);

	wire [31:0] status_word = (32'(skip_q) << ST_SKIP_LSB) | (32'(xing_q) << ST_XING_LSB) |
		(32'(gate_q) << ST_GATE_BIT) | (32'(state_q) << ST_STATE_LSB) |
		(32'(cmp_s.line_high) << ST_LINE_BIT) | (32'(startup_off_q) << ST_STARTOFF_BIT);
	wire [31:0] limit_word = 32'(limit_q) | (32'(ss_idx_q) << LIM_IDX_LSB);
	wire [31:0] rd_mux = hit_ctrl ? (32'(ctrl_en_q) << CTRL_EN_BIT) :
		hit_zone ? 32'(zone_q) :
		hit_status ? status_word :
		hit_limit ? limit_word : 32'h0;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q <= ~(req & wait_q);
			if (avs_read && wait_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// writable registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en_q <= CTRL_EN_RST;
			zone_q <= ZONE_RST;
		end else if (wr_fire) begin
			if (hit_ctrl) begin
				ctrl_en_q <= avs_writedata[CTRL_EN_BIT];
			end
			if (hit_zone) begin
				zone_q <= avs_writedata[ZONE_W-1:0];
			end
		end
	end

	// outputs, all from flops
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign gate_drive = gate_q;
	assign startup_off = startup_off_q;
	assign skip_count = skip_q;
	assign cs_limit_mv = limit_q;
	assign low_zone_threshold = low_thr_q;
	assign high_zone_threshold = high_thr_q;

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_gate_rise;
		!gate_q ##1 gate_q;
	endsequence

	sequence s_supply_start;
		(state_q == ST_IDLE) && cmp_s.supply_on;
	endsequence

	skip_range_a: assert property (skip_q >= SKIP_MIN && skip_q <= SKIP_MAX)
		else $error("skip counter left 1..7");
	skip_hold_a: assert property (!period_end |=> skip_q == $past(skip_q))
		else $error("skip counter moved inside a period");
	skip_up_a: assert property (period_end && !low_now && !high_now && !reset_now |=>
		skip_q == ($past(skip_q) == SKIP_MAX ? SKIP_MAX : $past(skip_q) + 3'h1))
		else $error("skip counter did not count up");
	skip_keep_a: assert property (period_end && low_now && !high_now && !reset_now |=>
		$stable(skip_q))
		else $error("skip counter changed in hold zone");
	skip_down_a: assert property (period_end && high_now && !reset_now |=>
		skip_q == ($past(skip_q) == SKIP_MIN ? SKIP_MIN : $past(skip_q) - 3'h1))
		else $error("skip counter did not count down");
	skip_force_a: assert property (period_end && reset_now |=> skip_q == SKIP_MIN)
		else $error("skip counter not forced to one");
	zc_clear_a: assert property (gate_q |-> xing_q == 3'h0)
		else $error("zero-crossing count not cleared");
	gate_on_a: assert property (s_gate_rise |-> $past(rs_done &&
		(xing_q >= skip_q || off_max)))
		else $error("gate rose before valley condition");
	supply_start_a: assert property (s_supply_start |=> (state_q == ST_SOFT) &&
		startup_off_q ##1 limit_q == SS_START_MV)
		else $error("soft-start did not begin at supply on");
	ss_step_a: assert property (step_end && !ss_final |=>
		limit_q == $past(limit_q) + SS_STEP_MV)
		else $error("soft-start limit step wrong");
	ss_even_a: assert property ((state_q == ST_SOFT) && !step_end |=>
		$stable(limit_q) || state_q != ST_SOFT)
		else $error("soft-start limit moved off a step boundary");
	zone_sel_a: assert property (##1 1'b1 |-> low_thr_q == $past(low_thr_d) &&
		high_thr_q == $past(high_thr_d))
		else $error("zone threshold not following line level");

endmodule : vsc_ctrl
`default_nettype wire

//--- verif/vsc_afe_model.sv
// vsc_afe_model: comparators and power stage that face the controller.
// assumes levels from the bench and gate_drive from the controller on mclk.
`timescale 1ns/1ns
`default_nettype none
module vsc_afe_model
	import vsc_pkg::*;
(
	input wire logic mclk,
	input wire logic [1:0] fdbk_level,
	input wire logic supply_up,
	input wire logic line_hi,
	input wire logic [2:0] ring_n,
	input wire logic gate_drive,
	output var vsc_cmp_t cmp_in,
	output var int xing_seen
);
	int on_cyc = 0;
	int off_cyc = 0;
	logic ring_on;
	logic shunt_trip;
	logic xing_above;
	// shunt trips after a fixed on time; ring_n valleys, then the node settles low
	assign shunt_trip = gate_drive && (on_cyc >= 20);
	assign ring_on = !gate_drive && (off_cyc < 60 * int'(ring_n));
	assign xing_above = ring_on && ((off_cyc % 60) < 30);
	// one driver for the whole flag word, in field order; feedback thresholds are nested
	assign cmp_in = {line_hi, shunt_trip, xing_above, supply_up, (fdbk_level == 2'h3),
		(fdbk_level >= 2'h2), (fdbk_level >= 2'h1)};
	// on/off timers and a count of true falling crossings since switch-off
	always @(posedge mclk) begin
		on_cyc <= gate_drive ? on_cyc + 1 : 0;
		off_cyc <= gate_drive ? 0 : off_cyc + 1;
		if (gate_drive) begin
			xing_seen <= 0;
		end else if (ring_on && (off_cyc % 60) == 29) begin
			xing_seen <= xing_seen + 1;
		end
	end
endmodule : vsc_afe_model
`default_nettype wire

//--- verif/tb_valley_skip_softstart_ctrl.sv
// tb_valley_skip_softstart_ctrl: self-checking bench of vsc_ctrl with random feedback.
// assumes vsc_pkg and the comparator model; timing parameters are shortened.
`timescale 1ns/1ns
`default_nettype none
module tb_valley_skip_softstart_ctrl
	import vsc_pkg::*;
;
	localparam int P = 200;
	localparam int SS = 50;
	localparam int OM = 400;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	vsc_cmp_t cmp_in;
	logic gate_drive;
	logic startup_off;
	logic [2:0] skip_count;
	logic [9:0] cs_limit_mv;
	logic [3:0] low_zone_threshold;
	logic [3:0] high_zone_threshold;
	logic [1:0] fdbk_level = 2'h3;
	logic supply_up = 1'b0;
	logic line_hi = 1'b0;
	logic [2:0] ring_n = 3'h0;
	logic gate_prev = 1'b0;
	logic [2:0] skip_prev = 3'h1;
	int xing_seen;
	int cyc = 0;
	int off_len = 0;
	int rises = 0;
	int fail_count = 0;
	int check_count = 0;
	logic [1:0] tbl [16] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h2};

	vsc_ctrl #(.UPDATE_CYCLES(P), .SS_STEP_CYCLES(SS), .OFF_MAX_CYCLES(OM)) dut_u (
		.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in), .gate_drive(gate_drive),
		.startup_off(startup_off), .skip_count(skip_count), .cs_limit_mv(cs_limit_mv),
		.low_zone_threshold(low_zone_threshold), .high_zone_threshold(high_zone_threshold)
	);
	vsc_afe_model afe_u (
		.mclk(mclk), .fdbk_level(fdbk_level), .supply_up(supply_up), .line_hi(line_hi),
		.ring_n(ring_n), .gate_drive(gate_drive), .cmp_in(cmp_in), .xing_seen(xing_seen)
	);

	// free-running clock
	initial begin
		forever #4 mclk = ~mclk;
	end

	task automatic wrap_up();
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (n == 50) begin
			fail_count++;
			wrap_up();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// expected skip value after one update period at feedback level lv
	function automatic logic [2:0] skip_next(input logic [2:0] s, input logic [1:0] lv);
		if (lv == 2'h3)
			return SKIP_RST;
		if (lv == 2'h2)
			return (s > SKIP_MIN) ? s - 3'h1 : s;
		if (lv == 2'h0)
			return (s < SKIP_MAX) ? s + 3'h1 : s;
		return s;
	endfunction : skip_next

	// cycle count since reset and a watch on every switch-on
	always @(posedge mclk) begin
		cyc <= rst_n ? cyc + 1 : 0;
		gate_prev <= gate_drive;
		skip_prev <= skip_count;
		off_len <= gate_drive ? 0 : off_len + 1;
		// skip_prev is the skip value the controller used for this switch-on decision
		if (rst_n && gate_drive === 1'b1 && gate_prev === 1'b0) begin
			rises <= rises + 1;
			ring_n <= 3'($urandom_range(7));
			chk({31'h0, off_len >= RS_CYC - 2}, 32'h1);
			chk({31'h0, xing_seen >= skip_prev || off_len >= OM - 2}, 32'h1);
		end
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		wrap_up();
	end

	initial begin
		logic [31:0] rd;
		logic [31:0] zr;
		logic [1:0] lp;
		logic [1:0] ln;
		logic [2:0] es;
		int n;
		zr = $urandom(2);
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(32'(skip_count), 32'(SKIP_RST));
		chk(32'(cs_limit_mv), 32'(SS_START_MV));
		chk(32'(startup_off), 32'h0);
		chk(32'(low_zone_threshold), 32'h6);
		// registers: reset values, unmapped place, read-only place
		bus(1'b0, REG_CTRL, 32'h0, rd);
		chk(32'(rd[0]), 32'h1);
		bus(1'b0, 4'h2, 32'h0, rd);
		chk(rd, 32'h0);
		zr = $urandom;
		bus(1'b1, REG_ZONE, zr, rd);
		bus(1'b0, REG_ZONE, 32'h0, rd);
		chk(32'(rd[15:0]), 32'(zr[15:0]));
		chk(32'(high_zone_threshold), 32'(zr[7:4]));
		line_hi <= 1'b1;
		repeat (5) @(posedge mclk);
		chk(32'(low_zone_threshold), 32'(zr[11:8]));
		chk(32'(high_zone_threshold), 32'(zr[15:12]));
		bus(1'b1, REG_LIMIT, 32'h0, rd);
		bus(1'b0, REG_LIMIT, 32'h0, rd);
		chk(32'(rd[9:0]), 32'(SS_START_MV));
		// soft start: sample the limit in the middle of each step
		supply_up <= 1'b1;
		for (n = 0; n < 10 && startup_off !== 1'b1; n++)
			@(posedge mclk);
		chk(32'(startup_off), 32'h1);
		repeat (SS / 2) @(posedge mclk);
		for (n = 0; n < 5; n++) begin
			chk(32'(cs_limit_mv), 32'(SS_START_MV) + 32'(n) * 32'(SS_STEP_MV));
			repeat (SS) @(posedge mclk);
		end
		chk(32'(cs_limit_mv), 32'(SS_FINAL_MV));
		// switching enable cleared: the gate falls and stays low, then enable again
		bus(1'b1, REG_CTRL, 32'h0, rd);
		repeat (3) @(posedge mclk);
		chk(32'(gate_drive), 32'h0);
		bus(1'b0, REG_CTRL, 32'h0, rd);
		chk(32'(rd[0]), 32'h0);
		bus(1'b1, REG_CTRL, 32'h1, rd);
		// skip counter: level changes mid-period, so each period sees two levels
		lp = 2'h3;
		es = SKIP_RST;
		for (int k = 0; k < 32; k++) begin
			for (n = 0; n < P && (cyc % P) != P / 2; n++)
				@(posedge mclk);
			chk(32'(skip_count), 32'(es));
			ln = (k < 16) ? tbl[k] : 2'($urandom_range(3));
			fdbk_level <= ln;
			bus(1'b0, REG_STATUS, 32'h0, rd);
			chk(32'(rd[2:0]), 32'(es));
			if (rd[8] === 1'b1)
				chk(32'(rd[6:4]), 32'h0);
			es = skip_next(es, (ln > lp) ? ln : lp);
			lp = ln;
		end
		chk(32'(rises > 5), 32'h1);
		wrap_up();
	end
endmodule : tb_valley_skip_softstart_ctrl
`default_nettype wire
